// ==== rtl/ffm_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Two independent detectors; second register set mirrors the first four words up.
// - Latch enable set: event active holds until software reads the source register.
// - Latch enable clear: source register shows live status every evaluation.
// - Combine select: 0 needs all enabled flags true, 1 needs any one.
// - Enabled axis high flag sets when magnitude is above the threshold.
// - Enabled axis low flag sets when magnitude is below the threshold.
// - Low compare uses the unsigned 7-bit threshold against axis magnitudes.
// - High compare uses the same threshold against axis magnitudes.
// - Event active sets when the selected combination of enabled flags is true.
// - Source: bit 7 zero, bit 6 event active, bits 5..0 axis flags.
// - Only event active latches; axis flags keep following live detection.
// - Event active goes to interrupt gating and routing onto an interrupt line.
// - Reset clears all configuration bits and source flags to zero.
// - Event flag asserts only once the debounce counter exceeds the count value.
// - Debounce mode 1 clears the counter on false; mode 0 decrements to zero.
module ffm_top (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         clk_en,
  input  wire logic                         sample_valid,
  input  wire logic [ffm_pkg::SAMPLE_W-1:0] accel_x,
  input  wire logic [ffm_pkg::SAMPLE_W-1:0] accel_y,
  input  wire logic [ffm_pkg::SAMPLE_W-1:0] accel_z,
  input  wire logic [ffm_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [ffm_pkg::DATA_W-1:0]   reg_wdata,
  output logic      [ffm_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic [ffm_pkg::NUM_CH-1:0]   fall_motion_irq_enable,
  input  wire logic [ffm_pkg::NUM_CH-1:0]   fall_motion_irq_route,
  output logic      [ffm_pkg::NUM_CH-1:0]   event_active,
  output logic                              irq_line1,
  output logic                              irq_line2
);

  // -------------------------------------------------------------------------
  // Shared axis magnitudes
  // -------------------------------------------------------------------------
  wire logic [ffm_pkg::NUM_AXES-1:0][ffm_pkg::THS_W-1:0] magnitude;
  wire logic                                             evaluate;

  // Detectors only advance on a new sample
  assign evaluate = clk_en & sample_valid;

  ffm_magnitude u_mag_x (
    .sample    (accel_x),
    .magnitude (magnitude[0])
  );

  ffm_magnitude u_mag_y (
    .sample    (accel_y),
    .magnitude (magnitude[1])
  );

  ffm_magnitude u_mag_z (
    .sample    (accel_z),
    .magnitude (magnitude[2])
  );

  // -------------------------------------------------------------------------
  // Register storage and per-channel state
  // -------------------------------------------------------------------------
  ffm_pkg::ffm_cfg_t                    cfg_reg     [ffm_pkg::NUM_CH];
  ffm_pkg::ffm_ths_t                    ths_reg     [ffm_pkg::NUM_CH];
  logic [ffm_pkg::CNT_W-1:0]            count_reg   [ffm_pkg::NUM_CH];
  logic [ffm_pkg::CNT_W-1:0]            debounce_reg[ffm_pkg::NUM_CH];
  ffm_pkg::ffm_flags_t                  flags_reg   [ffm_pkg::NUM_CH];
  logic [ffm_pkg::NUM_CH-1:0]           ea_reg;

  wire logic [ffm_pkg::DATA_W-1:0]      rd_part     [ffm_pkg::NUM_CH];
  wire logic [ffm_pkg::NUM_CH-1:0]      rd_hit;
  wire logic [ffm_pkg::DATA_W-1:0]      rd_mux;

  // -------------------------------------------------------------------------
  // Detector channels
  // -------------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < ffm_pkg::NUM_CH; ch++) begin : g_ch
      localparam logic [ffm_pkg::ADDR_W-1:0] OFS = 8'(ch) * ffm_pkg::CH_STRIDE;

      wire logic                        sel_cfg;
      wire logic                        sel_src;
      wire logic                        sel_ths;
      wire logic                        sel_count;
      wire logic                        src_read;
      wire ffm_pkg::ffm_flags_t         live_flags;
      wire logic                        condition;
      wire logic [ffm_pkg::CNT_W-1:0]   cnt_inc;
      wire logic [ffm_pkg::CNT_W-1:0]   cnt_dec;
      wire logic [ffm_pkg::CNT_W-1:0]   cnt_next;
      wire logic                        hit;
      wire logic                        ea_next;
      wire ffm_pkg::ffm_src_t           src_view;

      // ---------------------------------------------------------------------
      // Address decode
      // ---------------------------------------------------------------------
      assign sel_cfg   = (reg_addr == ffm_pkg::ADDR_CONFIG_A + OFS);
      assign sel_src   = (reg_addr == ffm_pkg::ADDR_SOURCE_A + OFS);
      assign sel_ths   = (reg_addr == ffm_pkg::ADDR_THRESHOLD_A + OFS);
      assign sel_count = (reg_addr == ffm_pkg::ADDR_COUNT_A + OFS);
      assign src_read  = clk_en & reg_rd & sel_src;

      // ---------------------------------------------------------------------
      // Compare and merge
      // ---------------------------------------------------------------------
      ffm_combine u_combine (
        .magnitude (magnitude),
        .threshold (ths_reg[ch].fall_motion_threshold),
        .cfg       (cfg_reg[ch]),
        .flags     (live_flags),
        .condition (condition)
      );

      // ---------------------------------------------------------------------
      // Debounce counter
      // ---------------------------------------------------------------------
      assign cnt_inc  = (debounce_reg[ch] == ffm_pkg::CNT_MAX) ?
                        debounce_reg[ch] : debounce_reg[ch] + 8'h01;
      assign cnt_dec  = (debounce_reg[ch] == 8'h00) ?
                        8'h00 : debounce_reg[ch] - 8'h01;
      assign cnt_next = condition ? cnt_inc :
                        (ths_reg[ch].debounce_mode ? 8'h00 : cnt_dec);
      assign hit      = condition && (cnt_next > count_reg[ch]);

      // ---------------------------------------------------------------------
      // Event active: latched or live
      // ---------------------------------------------------------------------
      // A fresh hit wins over a same-cycle clear by read
      assign ea_next = cfg_reg[ch].event_latch_enable ?
                       ((evaluate & hit) | (ea_reg[ch] & ~src_read)) :
                       (evaluate ? hit : ea_reg[ch]);

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          debounce_reg[ch] <= 8'h00;
          flags_reg[ch]    <= ffm_pkg::FLAGS_RESET;
          ea_reg[ch]       <= 1'b0;
        end else if (clk_en) begin
          ea_reg[ch] <= ea_next;
          if (sample_valid) begin
            debounce_reg[ch] <= cnt_next;
            flags_reg[ch]    <= live_flags;
          end
        end
      end

      // ---------------------------------------------------------------------
      // Register writes
      // ---------------------------------------------------------------------
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cfg_reg[ch]   <= ffm_pkg::CONFIG_RESET;
          ths_reg[ch]   <= ffm_pkg::THRESHOLD_RESET;
          count_reg[ch] <= ffm_pkg::COUNT_RESET;
        end else if (clk_en && reg_wr) begin
          if (sel_cfg) begin
            cfg_reg[ch] <= reg_wdata;
          end else if (sel_ths) begin
            ths_reg[ch] <= reg_wdata;
          end else if (sel_count) begin
            count_reg[ch] <= reg_wdata;
          end
        end
      end

      // ---------------------------------------------------------------------
      // Read view
      // ---------------------------------------------------------------------
      assign src_view.reserved     = 1'b0;
      assign src_view.event_active = ea_reg[ch];
      assign src_view.flags        = flags_reg[ch];

      assign rd_hit[ch]  = sel_cfg | sel_src | sel_ths | sel_count;
      assign rd_part[ch] = sel_cfg   ? cfg_reg[ch] :
                           sel_src   ? src_view :
                           sel_ths   ? ths_reg[ch] :
                           sel_count ? count_reg[ch] :
                           ffm_pkg::READ_UNMAPPED;
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------------------
  // Address ranges of the two sets never overlap, so an OR selects
  assign rd_mux = (rd_hit != 2'b00) ? (rd_part[0] | rd_part[1]) : ffm_pkg::READ_UNMAPPED;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata  <= ffm_pkg::READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt gating and routing
  // -------------------------------------------------------------------------
  wire logic [ffm_pkg::NUM_CH-1:0] ea_gated;
  wire logic                       line1_next;
  wire logic                       line2_next;

  assign ea_gated   = ea_reg & fall_motion_irq_enable;
  assign line1_next = |(ea_gated & fall_motion_irq_route);
  assign line2_next = |(ea_gated & ~fall_motion_irq_route);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_active <= 2'b00;
      irq_line1    <= 1'b0;
      irq_line2    <= 1'b0;
    end else if (clk_en) begin
      event_active <= ea_reg;
      irq_line1    <= line1_next;
      irq_line2    <= line2_next;
    end
  end

endmodule : ffm_top

// ==== inc/ffm_pkg.sv ====
// ---------------------------------------------------------------------------
// Freefall / motion detector shared definitions
// ---------------------------------------------------------------------------
package ffm_pkg;

  // -------------------------------------------------------------------------
  // Widths and counts
  // -------------------------------------------------------------------------
  localparam int NUM_CH   = 2;
  localparam int NUM_AXES = 3;
  localparam int SAMPLE_W = 12;
  localparam int THS_W    = 7;
  localparam int CNT_W    = 8;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int FLAG_W   = 2 * NUM_AXES;

  // Magnitude bit that maps onto threshold bit 0
  localparam int MAG_THS_LSB = 4;

  // -------------------------------------------------------------------------
  // Register offsets, first set; the second set sits one stride higher
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONFIG_A    = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_SOURCE_A    = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_THRESHOLD_A = 8'h25;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_A     = 8'h26;
  localparam logic [ADDR_W-1:0] CH_STRIDE        = 8'h04;

  // -------------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] CONFIG_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] THRESHOLD_RESET = 8'h00;
  localparam logic [CNT_W-1:0]  COUNT_RESET     = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET     = 6'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED   = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_MAX         = 8'hFF;

  // -------------------------------------------------------------------------
  // Field layouts
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic event_latch_enable;
    logic combine_select;
    logic z_high_detect_enable;
    logic z_low_detect_enable;
    logic y_high_detect_enable;
    logic y_low_detect_enable;
    logic x_high_detect_enable;
    logic x_low_detect_enable;
  } ffm_cfg_t;

  typedef struct packed {
    logic             debounce_mode;
    logic [THS_W-1:0] fall_motion_threshold;
  } ffm_ths_t;

  typedef struct packed {
    logic z_high_flag;
    logic z_low_flag;
    logic y_high_flag;
    logic y_low_flag;
    logic x_high_flag;
    logic x_low_flag;
  } ffm_flags_t;

  typedef struct packed {
    logic       reserved;
    logic       event_active;
    ffm_flags_t flags;
  } ffm_src_t;

endpackage : ffm_pkg

// ==== rtl/ffm_magnitude.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Absolute value of one axis sample scaled to the threshold range
// ---------------------------------------------------------------------------
module ffm_magnitude (
  input  wire logic [ffm_pkg::SAMPLE_W-1:0] sample,
  output wire logic [ffm_pkg::THS_W-1:0]    magnitude
);

  wire logic [ffm_pkg::SAMPLE_W-1:0] abs_value;
  wire logic                         over_range;

  // Most negative code gives 2048, which saturates to the top of the range
  assign abs_value  = sample[ffm_pkg::SAMPLE_W-1] ? (~sample + 12'h001) : sample;
  assign over_range = abs_value[ffm_pkg::SAMPLE_W-1];
  assign magnitude  = over_range ? 7'h7F :
                      abs_value[ffm_pkg::MAG_THS_LSB +: ffm_pkg::THS_W];

endmodule : ffm_magnitude

// ==== rtl/ffm_combine.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Per-axis high/low compare and AND/OR merge for one detector
// ---------------------------------------------------------------------------
module ffm_combine (
  input  wire logic [ffm_pkg::NUM_AXES-1:0][ffm_pkg::THS_W-1:0] magnitude,
  input  wire logic [ffm_pkg::THS_W-1:0]                        threshold,
  input  wire ffm_pkg::ffm_cfg_t                                cfg,
  output wire ffm_pkg::ffm_flags_t                              flags,
  output wire logic                                             condition
);

  wire logic [ffm_pkg::FLAG_W-1:0] enables;
  wire logic [ffm_pkg::FLAG_W-1:0] raw_flags;
  wire logic                       all_true;
  wire logic                       any_true;

  assign enables = cfg[ffm_pkg::FLAG_W-1:0];

  // Axis a owns flag pair {high, low} at bits 2a+1 and 2a
  genvar a;
  generate
    for (a = 0; a < ffm_pkg::NUM_AXES; a++) begin : g_axis
      assign raw_flags[2*a+1] = enables[2*a+1] & (magnitude[a] > threshold);
      assign raw_flags[2*a]   = enables[2*a] & (magnitude[a] < threshold);
    end
  endgenerate

  // Nothing enabled never counts as an AND match
  assign all_true  = (enables != 6'h00) && (raw_flags == enables);
  assign any_true  = |raw_flags;
  assign condition = cfg.combine_select ? any_true : all_true;
  assign flags     = raw_flags;

endmodule : ffm_combine

// ==== tb/ffm_monitor.sv ====
`timescale 1ns/1ps
// --------------------------------
// Port checker of the detector
// --------------------------------
module ffm_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       sample_valid,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [1:0] fall_motion_irq_enable,
  input wire logic [1:0] fall_motion_irq_route,
  input wire logic [1:0] event_active,
  input wire logic       irq_line1,
  input wire logic       irq_line2
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_unmapped_zero: assert property (clk_en && reg_rd && (reg_addr < 8'h23 || reg_addr > 8'h2A)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_src_reserved: assert property (clk_en && reg_rd && (reg_addr == 8'h24 || reg_addr == 8'h28)
    |=> !reg_rdata[7]) else $error("source reserved bit set");
  a_rdata_hold: assert property (!reg_rvalid && !$past(sys_rst) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_rise_a_cause: assert property ($rose(event_active[0]) |-> $past(sample_valid, 2))
    else $error("event A rose without a sample");
  a_rise_b_cause: assert property ($rose(event_active[1]) |-> $past(sample_valid, 2))
    else $error("event B rose without a sample");
  a_enable_freeze: assert property (!clk_en |=> $stable(event_active) && $stable(reg_rvalid)
    && $stable(irq_line1) && $stable(irq_line2)) else $error("state moved while enable low");
  a_fall_a_cause: assert property ($fell(event_active[0]) && !$past(sys_rst)
    |-> $past(sample_valid, 2) || $past(reg_rd && reg_addr == 8'h24, 2))
    else $error("event A fell without sample or read");
  a_irq_one_route: assert property ($stable(fall_motion_irq_enable)
    && $stable(fall_motion_irq_route) |-> irq_line1 ==
    |(event_active & fall_motion_irq_enable & fall_motion_irq_route)) else $error("line1 wrong");
  a_irq_two_route: assert property ($stable(fall_motion_irq_enable)
    && $stable(fall_motion_irq_route) |-> irq_line2 ==
    |(event_active & fall_motion_irq_enable & ~fall_motion_irq_route)) else $error("line2 wrong");
endmodule : ffm_monitor

bind ffm_top ffm_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .sample_valid(sample_valid), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .fall_motion_irq_enable(fall_motion_irq_enable),
  .fall_motion_irq_route(fall_motion_irq_route), .event_active(event_active),
  .irq_line1(irq_line1), .irq_line2(irq_line2));

// ==== tb/ffm_host.sv ====
`timescale 1ns/1ps
// --------------------------------
// Host processor on the register port
// --------------------------------
module ffm_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
    @(posedge clk);
    #1;
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'h0};
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    {reg_addr, reg_rd} = {a, 1'h1};
    @(posedge clk);
    #1;
    {reg_addr, reg_rd} = {~a, 1'h0};
  endtask : rd
endmodule : ffm_host

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp); \
  end \
end
// --------------------------------
// Bench of the detector
// --------------------------------
module testbench;
  logic        clk, sys_rst, clk_en, sample_valid, reg_wr, reg_rd, reg_rvalid;
  logic        irq_line1, irq_line2;
  logic [35:0] acc, v;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, exp_v;
  logic [1:0]  irq_en, irq_route, event_active;
  logic [7:0]  cfg[2];
  logic [6:0]  thr[2];
  logic [7:0]  exp_q[$];
  logic [8:0]  hits = 9'h12E;
  logic [8:0]  eas  = 9'h028;
  logic [31:0] seed = 32'h0001_6CAF;
  int          error_cnt = 0;
  int          cmp_count = 0;

  ffm_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sample_valid(sample_valid),
    .accel_x(acc[11:0]), .accel_y(acc[23:12]), .accel_z(acc[35:24]),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fall_motion_irq_enable(irq_en),
    .fall_motion_irq_route(irq_route), .event_active(event_active),
    .irq_line1(irq_line1), .irq_line2(irq_line2));
  ffm_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [6:0] mag(input logic [11:0] s);
    logic [11:0] a;
    a = s[11] ? 12'h000 - s : s;
    return (s == 12'h800) ? 7'h7F : a[10:4];
  endfunction : mag

  function automatic logic [7:0] src(input logic [7:0] c, input logic [6:0] t,
                                     input logic [35:0] w);
    logic [5:0] f;
    for (int i = 0; i < 3; i++) begin
      f[2*i+1] = c[2*i+1] & (mag(w[12*i+:12]) > t);
      f[2*i]   = c[2*i] & (mag(w[12*i+:12]) < t);
    end
    return {1'h0, c[6] ? |f : (c[5:0] != 6'h00 && f == c[5:0]), f};
  endfunction : src

  task automatic nxt;
    repeat (32) seed = lfsr(seed);
  endtask : nxt

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask : rd

  task automatic smp(input logic [35:0] w);
    @(posedge clk);
    #1;
    {acc, sample_valid} = {w, 1'h1};
    @(posedge clk);
    #1;
    {acc, sample_valid} = {~w, 1'h0};
  endtask : smp

  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    if (reg_rvalid === 1'h1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(reg_rdata, exp_v, "register read")
    end
  end

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    {sys_rst, clk_en, sample_valid, irq_en, irq_route, acc} = {3'h6, 4'h0, 36'h0};
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    for (int a = 8'h22; a < 8'h2C; a++) rd(a[7:0], 8'h00);
    for (int a = 8'h23; a < 8'h2B; a++) begin
      nxt();
      i_host.wr(a[7:0], seed[7:0]);
      rd(a[7:0], (a == 8'h24 || a == 8'h28) ? 8'h00 : seed[7:0]);
    end
    i_host.wr(8'h26, 8'h00);
    i_host.wr(8'h2A, 8'h00);
    for (int i = 0; i < 60; i++) begin
      for (int ch = 0; ch < 2; ch++) begin
        nxt();
        cfg[ch] = {1'h0, seed[6:0]};
        thr[ch] = seed[14:8];
        i_host.wr(8'h23 + 8'(4 * ch), cfg[ch]);
        i_host.wr(8'h25 + 8'(4 * ch), {seed[15], thr[ch]});
      end
      nxt();
      {irq_route, irq_en, v[35:12]} = seed[27:0];
      nxt();
      v[11:0] = (i % 4 == 0) ? {1'h0, thr[0], 4'h0} : seed[11:0];
      smp(v);
      rd(8'h24, src(cfg[0], thr[0], v));
      rd(8'h28, src(cfg[1], thr[1], v));
    end
    i_host.wr(8'h23, 8'hC2);
    i_host.wr(8'h25, 8'h10);
    smp(36'h200);
    smp(36'h000);
    rd(8'h24, 8'h40);
    rd(8'h24, 8'h00);
    fork
      smp(36'h200);
      rd(8'h24, 8'h00);
    join
    rd(8'h24, 8'h42);
    i_host.wr(8'h23, 8'h42);
    i_host.wr(8'h26, 8'h02);
    i_host.wr(8'h25, 8'h90);
    for (int i = 0; i < 9; i++) begin
      if (i == 4) i_host.wr(8'h25, 8'h10);
      smp(hits[i] ? 36'h200 : 36'h000);
      rd(8'h24, {1'h0, eas[i], 4'h0, hits[i], 1'h0});
    end
    @(posedge clk);
    #1;
    clk_en = 1'h0;
    smp(36'h000);
    clk_en = 1'h1;
    rd(8'h24, 8'h02);
    sys_rst = 1'h1;
    @(posedge clk);
    #1;
    sys_rst = 1'h0;
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h00);
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0, "pending reads")
    close_out();
  end
endmodule : testbench
